// *** hdl/link_status_pkg.sv ***
package link_status_pkg;

   // Register byte offsets on the AHB-Lite slave.
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_COUNTS = 8'h08;
   localparam logic [7:0] OFS_BUCKET = 8'h0c;

   // Control register fields and reset value.
   localparam int CTRL_RESET_BIT   = 0;
   localparam int CTRL_PDOWN_BIT   = 1;
   localparam int CTRL_SIMPLEX_BIT = 2;
   localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

   // Status register fields.
   localparam int STAT_LANE_LSB  = 0;
   localparam int STAT_CHAN_BIT  = 16;
   localparam int STAT_FATAL_BIT = 17;
   localparam int STAT_STATE_LSB = 20;

   // Event counter fields.
   localparam int CNT_SOFT_LSB  = 0;
   localparam int CNT_FRAME_LSB = 16;
   localparam int CNT_HARD_LSB  = 24;

   // Timing counts and burst detector defaults.
   localparam int RESET_HOLD_CYCLES   = 16;
   localparam int BUCKET_INC          = 4;
   localparam int BUCKET_DECAY_CYCLES = 64;
   localparam int BUCKET_TRIP         = 15;
   localparam int DEBOUNCE_STAGES     = 4;
   localparam int MAX_LANES           = 16;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   // Initialisation states.
   typedef enum logic [2:0] {
      ST_RESET  = 3'b000,
      ST_LANE   = 3'b001,
      ST_BOND   = 3'b010,
      ST_VERIFY = 3'b011,
      ST_UP     = 3'b100
   } init_state_t;

   // Transceiver and protocol engine hard fault sources.
   typedef struct packed {
      logic tx_buf_err;   // Transmit elastic buffer over- or underflow.
      logic rx_buf_err;   // Receive elastic buffer over- or underflow.
      logic bad_ctrl_tx;  // Engine tried to send an invalid control character.
   } hw_err_t;

   // Received framing symbols for one cycle.
   typedef struct packed {
      logic sof;           // Start of frame seen.
      logic eof;           // End of frame seen.
      logic data;          // Data beat seen.
      logic ctrl_unknown;  // Unrecognised control character.
   } frame_sym_t;

endpackage

// *** hdl/serial_link_status_and_errors.sv ***
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
module serial_link_status_and_errors
   import link_status_pkg::*;
#(
   parameter int LANES        = 4,
   parameter int HOLD_CYCLES  = RESET_HOLD_CYCLES,
   parameter int INC          = BUCKET_INC,
   parameter int DECAY_CYCLES = BUCKET_DECAY_CYCLES,
   parameter int TRIP         = BUCKET_TRIP
) (
   input  wire logic             clk,                   // User clock, 50 MHz.
   input  wire logic             arst_n,                // Asynchronous reset, active low.
   input  wire logic             init_clk,              // Slow free-running board clock.
   input  wire logic             core_reset_in,         // Synchronous core reset, high.
   input  wire logic             power_down_in,         // Transceiver power-down request.
   input  wire logic             transceiver_reset_raw, // Undebounced transceiver reset.
   input  wire logic [LANES-1:0] lane_aligned_in,       // Per-lane initialisation done.
   input  wire logic             bond_done_in,          // Channel bonding done.
   input  wire logic             verify_done_in,        // Verification step done.
   input  wire logic             partner_aligned_in,    // Simplex partner lanes aligned.
   input  wire logic             partner_bonded_in,     // Simplex partner bonded.
   input  wire logic             partner_verified_in,   // Simplex partner verified.
   input  wire logic             partner_restart_in,    // Simplex partner restart request.
   input  wire logic [LANES-1:0] code_invalid_in,       // Per-lane invalid code group.
   input  wire logic [LANES-1:0] disparity_err_in,      // Per-lane disparity error.
   input  wire hw_err_t          hw_err_in,             // Hard fault sources.
   input  wire frame_sym_t       frame_sym_in,          // Received framing symbols.
   output logic                  channel_up,            // Channel ready.
   output logic [LANES-1:0]      lane_up,               // Per-lane ready.
   output logic                  rx_deliver_en,         // Received data may be delivered.
   output logic                  lane_restart,          // Held high while core resets.
   output logic                  frame_fault,           // One-cycle framing fault.
   output logic                  symbol_fault,          // One-cycle soft error.
   output logic                  fatal_fault,           // Sticky hard error.
   output logic                  transceiver_pdown,     // To transceiver power-down.
   output logic                  transceiver_reset,     // Debounced, init_clk domain.
   input  wire logic             hsel,                  // AHB slave select.
   input  wire logic [31:0]      haddr,                 // AHB address.
   input  wire logic [1:0]       htrans,                // AHB transfer type.
   input  wire logic             hwrite,                // AHB write.
   input  wire logic [2:0]       hsize,                 // AHB size.
   input  wire logic [31:0]      hwdata,                // AHB write data.
   input  wire logic             hready,                // AHB bus ready.
   output logic                  hreadyout,             // AHB slave ready.
   output logic [31:0]           hrdata,                // AHB read data.
   output logic                  hresp                  // AHB response, always OKAY.
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.

   if (LANES < 1 || LANES > MAX_LANES) begin
      $error("LANES must lie between 1 and 16");
   end
   if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255) begin
      $error("HOLD_CYCLES must lie between 1 and 255");
   end
   if (INC < 1 || TRIP < 1 || TRIP > 255 || DECAY_CYCLES < 1 || DECAY_CYCLES > 65535) begin
      $error("Burst detector parameters out of range");
   end

   localparam logic [7:0]  HOLD_LOAD = 8'(HOLD_CYCLES - 1);
   localparam logic [7:0]  INC_V     = 8'(INC);
   localparam logic [7:0]  TRIP_V    = 8'(TRIP);
   localparam logic [15:0] DECAY_V   = 16'(DECAY_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Register state and bus capture.

   logic        [31:0] ctrl_reg;
   logic               wr_pend_reg;
   logic        [7:0]  wr_addr_reg;
   init_state_t        state_reg;
   logic        [7:0]  hold_reg;
   logic        [7:0]  bucket_reg;
   logic        [15:0] decay_reg;
   logic               in_frame_reg;
   logic               has_data_reg;
   logic        [15:0] soft_cnt_reg;
   logic        [7:0]  frame_cnt_reg;
   logic        [7:0]  hard_cnt_reg;

   logic simplex;
   logic addr_take;
   logic wr_ctrl;
   logic wr_counts;
   logic reset_req;
   logic rx_active;
   logic soft_event;
   logic frame_event;
   logic bucket_trip;
   logic hard_event;
   logic lanes_ok;
   logic [7:0] bucket_next;

   assign simplex   = ctrl_reg[CTRL_SIMPLEX_BIT];
   assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign wr_ctrl   = wr_pend_reg && (wr_addr_reg == OFS_CTRL);
   assign wr_counts = wr_pend_reg && (wr_addr_reg == OFS_COUNTS);

   // Address phase capture; the slave never inserts wait states.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         wr_pend_reg <= addr_take && hwrite;
         wr_addr_reg <= addr_take ? haddr[7:0] : wr_addr_reg;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end
   end

   // Control register; the reset bit self-clears so it acts as one pulse.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= CTRL_RESET_VAL;
      end else if (wr_ctrl) begin
         ctrl_reg <= {29'h0, hwdata[CTRL_SIMPLEX_BIT], hwdata[CTRL_PDOWN_BIT],
                      hwdata[CTRL_RESET_BIT]};
      end else begin
         ctrl_reg[CTRL_RESET_BIT] <= 1'b0;
      end
   end

   // Read data is prepared at the address phase so it stands in the data phase.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_take && !hwrite) begin
         unique case (haddr[7:0])
            OFS_CTRL:   hrdata <= ctrl_reg;
            OFS_STATUS: hrdata <= {9'h0, state_reg, 2'h0, fatal_fault, channel_up,
                                   16'(lane_up)};
            OFS_COUNTS: hrdata <= {hard_cnt_reg, frame_cnt_reg, soft_cnt_reg};
            OFS_BUCKET: hrdata <= {24'h0, bucket_reg};
            default:    hrdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Initialisation sequencing.

   // Every reset source funnels into the same hold-and-restart path.
   assign reset_req = core_reset_in
                    || ctrl_reg[CTRL_RESET_BIT]
                    || (simplex && partner_restart_in)
                    || hard_event;
   assign lanes_ok = simplex ? partner_aligned_in : &lane_aligned_in;

   // A lost lane drops back to lane initialisation rather than a full reset.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_RESET;
         hold_reg  <= HOLD_LOAD;
      end else if (reset_req) begin
         state_reg <= ST_RESET;
         hold_reg  <= HOLD_LOAD;
      end else begin
         unique case (state_reg)
            ST_RESET: begin
               if (hold_reg == 8'h00) begin
                  state_reg <= ST_LANE;
               end else begin
                  hold_reg <= hold_reg - 8'h01;
               end
            end
            ST_LANE: begin
               if (lanes_ok) begin
                  state_reg <= (LANES == 1) ? ST_VERIFY : ST_BOND;
               end
            end
            ST_BOND: begin
               if (!lanes_ok) begin
                  state_reg <= ST_LANE;
               end else if (simplex ? partner_bonded_in : bond_done_in) begin
                  state_reg <= ST_VERIFY;
               end
            end
            ST_VERIFY: begin
               if (!lanes_ok) begin
                  state_reg <= ST_LANE;
               end else if (simplex ? partner_verified_in : verify_done_in) begin
                  state_reg <= ST_UP;
               end
            end
            ST_UP: begin
               if (!lanes_ok) begin
                  state_reg <= ST_LANE;
               end
            end
            default: begin
               state_reg <= ST_RESET;
               hold_reg  <= HOLD_LOAD;
            end
         endcase
      end
   end

   // Ready outputs; data delivery needs the channel and every lane ready.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         channel_up    <= 1'b0;
         lane_up       <= '0;
         rx_deliver_en <= 1'b0;
         lane_restart  <= 1'b1;
      end else begin
         channel_up    <= !reset_req && (state_reg == ST_UP) && lanes_ok;
         lane_up       <= (reset_req || state_reg == ST_RESET) ? '0 :
                          simplex ? {LANES{partner_aligned_in}} :
                          lane_aligned_in;
         rx_deliver_en <= !reset_req && !simplex && (state_reg == ST_UP)
                          && (&lane_aligned_in);
         lane_restart  <= reset_req || (state_reg == ST_RESET);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Soft errors and the burst detector.

   // Receive checks sleep while resetting and in transmit-only mode.
   assign rx_active  = !simplex && (state_reg != ST_RESET);
   assign soft_event = rx_active && (|code_invalid_in
                                  || |disparity_err_in);

   // Decay one token per period; a soft error cycle adds INC tokens.
   always_comb begin
      bucket_next = bucket_reg;
      if (decay_reg == 16'h0000 && bucket_next != 8'h00) begin
         bucket_next = bucket_next - 8'h01;
      end
      if (soft_event) begin
         bucket_next = (bucket_next > 8'hff - INC_V) ? 8'hff : bucket_next + INC_V;
      end
   end
   assign bucket_trip = soft_event && (bucket_next >= TRIP_V);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bucket_reg <= 8'h00;
         decay_reg  <= DECAY_V;
      end else if (state_reg == ST_RESET) begin
         bucket_reg <= 8'h00;
         decay_reg  <= DECAY_V;
      end else begin
         bucket_reg <= bucket_next;
         decay_reg  <= (decay_reg == 16'h0000) ? DECAY_V : decay_reg - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Hard errors.

   // Faults during the reset hold are the aftermath of the reset itself.
   assign hard_event = (state_reg != ST_RESET)
                    && (hw_err_in.tx_buf_err
                        || (!simplex && hw_err_in.rx_buf_err)
                        || hw_err_in.bad_ctrl_tx
                        || bucket_trip);

   // Set on a hard error, clear only when the reset hold runs out.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fatal_fault <= 1'b0;
      end else if (hard_event) begin
         fatal_fault <= 1'b1;
      end else if (state_reg == ST_RESET && hold_reg == 8'h00) begin
         fatal_fault <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame checking.

   // A frame may open and close in one cycle; it still needs a data beat.
   always_comb begin
      frame_event = 1'b0;
      if (rx_active && state_reg == ST_UP) begin
         if (frame_sym_in.sof && in_frame_reg) begin
            frame_event = 1'b1;
         end
         if (frame_sym_in.eof && !in_frame_reg && !frame_sym_in.sof) begin
            frame_event = 1'b1;
         end
         if (frame_sym_in.eof && !frame_sym_in.data
             && !(has_data_reg && in_frame_reg && !frame_sym_in.sof)) begin
            frame_event = 1'b1;
         end
         if (frame_sym_in.ctrl_unknown) begin
            frame_event = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         in_frame_reg <= 1'b0;
         has_data_reg <= 1'b0;
      end else if (!rx_active || state_reg != ST_UP) begin
         in_frame_reg <= 1'b0;
         has_data_reg <= 1'b0;
      end else if (frame_sym_in.eof) begin
         in_frame_reg <= 1'b0;
         has_data_reg <= 1'b0;
      end else if (frame_sym_in.sof) begin
         in_frame_reg <= 1'b1;
         has_data_reg <= frame_sym_in.data;
      end else if (frame_sym_in.data && in_frame_reg) begin
         has_data_reg <= 1'b1;
      end
   end

   // Fault pulses last one cycle each and follow their cause by one edge.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         symbol_fault <= 1'b0;
         frame_fault  <= 1'b0;
      end else begin
         symbol_fault <= soft_event;
         frame_fault  <= frame_event;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event counters; a count arriving with a clear still counts.

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         soft_cnt_reg  <= 16'h0000;
         frame_cnt_reg <= 8'h00;
         hard_cnt_reg  <= 8'h00;
      end else begin
         if (soft_event) begin
            soft_cnt_reg <= wr_counts ? 16'h0001 :
                            (soft_cnt_reg == 16'hffff) ? soft_cnt_reg : soft_cnt_reg + 16'h0001;
         end else if (wr_counts) begin
            soft_cnt_reg <= 16'h0000;
         end
         if (frame_event) begin
            frame_cnt_reg <= wr_counts ? 8'h01 :
                             (frame_cnt_reg == 8'hff) ? frame_cnt_reg : frame_cnt_reg + 8'h01;
         end else if (wr_counts) begin
            frame_cnt_reg <= 8'h00;
         end
         if (hard_event) begin
            hard_cnt_reg <= wr_counts ? 8'h01 :
                            (hard_cnt_reg == 8'hff) ? hard_cnt_reg : hard_cnt_reg + 8'h01;
         end else if (wr_counts) begin
            hard_cnt_reg <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transceiver controls.

   // Power-down follows the pin or the control bit with one flop of delay.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         transceiver_pdown <= 1'b0;
      end else begin
         transceiver_pdown <= power_down_in || ctrl_reg[CTRL_PDOWN_BIT];
      end
   end

   // The user clock stops while the transceiver is in reset, so this runs on init_clk.
   logic                       sync1_reg;
   logic                       sync2_reg;
   logic [DEBOUNCE_STAGES-1:0] deb_reg;

   always_ff @(posedge init_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg         <= 1'b0;
         sync2_reg         <= 1'b0;
         deb_reg           <= '0;
         transceiver_reset <= 1'b0;
      end else begin
         sync1_reg <= transceiver_reset_raw;
         sync2_reg <= sync1_reg;
         deb_reg   <= {deb_reg[DEBOUNCE_STAGES-2:0], sync2_reg};
         if (&deb_reg) begin
            transceiver_reset <= 1'b1;
         end else if (deb_reg == '0) begin
            transceiver_reset <= 1'b0;
         end
      end
   end

endmodule

// *** test/link_partner.sv ***
`timescale 1ns/100ps
module link_partner #(
   parameter int LANES = 4,
   parameter int DELAY = 3
) (
   input  wire logic        clk,      // Core clock.
   input  wire logic        arst_n,   // Asynchronous reset, active low.
   input  wire logic        lanes_on, // Low while the near side restarts.
   output logic [LANES-1:0] aligned,  // Lane initialisation done.
   output logic             bonded,   // Channel bonding done.
   output logic             verified  // Verification done.
);
   logic [7:0] step_reg;
   // Stages finish in order; a near-side restart drops them all, as real lanes would.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         step_reg <= '0;
      else if (!lanes_on)
         step_reg <= '0;
      else if (step_reg != 8'hff)
         step_reg <= step_reg + 8'h01;
   end
   assign aligned  = {LANES{step_reg >= DELAY}};
   assign bonded   = step_reg >= 2 * DELAY;
   assign verified = step_reg >= 3 * DELAY;
endmodule

// *** test/serial_link_status_and_errors_props.sv ***
`timescale 1ns/100ps
module link_status_props
   import link_status_pkg::*;
#(parameter int LANES = 4) (
   input wire logic             clk,              // Core clock.
   input wire logic             arst_n,           // Reset, active low.
   input wire logic             power_down_in,    // Power-down request.
   input wire logic [LANES-1:0] code_invalid_in,  // Invalid code flags.
   input wire logic [LANES-1:0] disparity_err_in, // Disparity flags.
   input wire hw_err_t          hw_err_in,        // Hard fault sources.
   input wire frame_sym_t       frame_sym_in,     // Framing symbols.
   input wire logic             channel_up,       // Channel ready.
   input wire logic [LANES-1:0] lane_up,          // Lane ready.
   input wire logic             rx_deliver_en,    // Delivery enable.
   input wire logic             frame_fault,      // Framing fault.
   input wire logic             symbol_fault,     // Soft error.
   input wire logic             fatal_fault,      // Hard error.
   input wire logic             transceiver_pdown // Power-down out.
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // The property checks a hard cause only while the channel runs; the core ignores one during the reset hold, and rx_buf_err in simplex mode.
   sequence hard_cause;
      channel_up && (|hw_err_in);
   endsequence
   sequence back_up;
      ##[1:60] channel_up;
   endsequence
   AST_FRAME_CAUSE: assert property (channel_up && frame_sym_in.ctrl_unknown |=> frame_fault)
      else $error("frame fault missing");
   AST_FRAME_ONLY: assert property (frame_fault |-> $past(frame_sym_in != 4'h0))
      else $error("frame fault without cause");
   AST_CODE: assert property (channel_up && (|code_invalid_in) |=> symbol_fault)
      else $error("invalid code not flagged");
   AST_DISP: assert property (channel_up && (|disparity_err_in) |=> symbol_fault)
      else $error("disparity not flagged");
   AST_SOFT_ONLY: assert property (symbol_fault |-> $past(|(code_invalid_in | disparity_err_in)))
      else $error("soft pulse without cause");
   AST_HARD: assert property (hard_cause |=> fatal_fault && !channel_up)
      else $error("hard error not raised");
   AST_FATAL_DOWN: assert property (fatal_fault |-> !channel_up && lane_up == '0)
      else $error("ready while fatal");
   AST_RESTART: assert property ($rose(fatal_fault) |-> back_up)
      else $error("no reinitialisation");
   AST_READY: assert property (channel_up |-> &lane_up)
      else $error("channel up without lanes");
   AST_DELIVER: assert property (rx_deliver_en |-> channel_up)
      else $error("delivery while down");
   AST_PDOWN: assert property (power_down_in |=> transceiver_pdown)
      else $error("power-down not passed");
endmodule
bind serial_link_status_and_errors link_status_props #(.LANES(LANES)) props_u (.*);

// *** test/serial_link_status_and_errors_bench.sv ***
`timescale 1ns/100ps
module serial_link_status_and_errors_bench;
   import link_status_pkg::*;
   localparam int LANES = 4;
   logic clk = 0, init_clk = 0, arst_n = 0, core_reset_in = 0, power_down_in = 0;
   logic transceiver_reset_raw = 0, partner_restart_in = 0, hsel = 0, hwrite = 0;
   logic partner_aligned_in, partner_bonded_in, partner_verified_in;
   logic [LANES-1:0] code_invalid_in = '0, disparity_err_in = '0, lane_aligned_in, lane_up;
   hw_err_t hw_err_in = '0;
   frame_sym_t frame_sym_in = '0;
   logic bond_done_in, verify_done_in, channel_up, rx_deliver_en, lane_restart, hready;
   logic frame_fault, symbol_fault, fatal_fault, transceiver_pdown, transceiver_reset;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic hreadyout, hresp;
   int fail_count = 0, cmp_count = 0;
   // Frame symbols with the expected fault in the low bit.
   logic [4:0] ftab [8] = '{5'b10100, 5'b01000, 5'b01001, 5'b10000, 5'b10001,
                            5'b01100, 5'b11001, 5'b00011};
   always #10 clk = ~clk;
   always #50 init_clk = ~init_clk;
   assign hready = hreadyout;
   serial_link_status_and_errors #(.HOLD_CYCLES(2), .DECAY_CYCLES(8)) dut_u (.*);
   link_partner #(.LANES(LANES)) partner_u (.clk(clk), .arst_n(arst_n),
      .lanes_on(!lane_restart), .aligned(lane_aligned_in), .bonded(bond_done_in),
      .verified(verify_done_in));
   // A single-lane receiving partner drives the simplex sideband inputs in order.
   link_partner #(.LANES(1)) side_u (.clk(clk), .arst_n(arst_n), .lanes_on(!lane_restart),
      .aligned(partner_aligned_in), .bonded(partner_bonded_in),
      .verified(partner_verified_in));
   ////////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait; running out is a mismatch and ends the run.
   task automatic wait_up;
      int n;
      n = 0;
      while (channel_up !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk(channel_up, 1);
      if (n == 300) wrap_up;
   endtask
   // One single AHB transfer: address phase, then data phase, each held until hready.
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      hsel <= 1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (hreadyout !== 1'b1 && n < 50);
         if (n == 50) chk(0, 1);
         if (n == 50) wrap_up;
         if (p == 0) begin
            hsel <= 0;
            htrans <= 2'b00;
            hwdata <= d;
         end
      end
      rd = hrdata;
      chk(hresp, 0);
   endtask
   task automatic pulse(input frame_sym_t s, input logic [LANES-1:0] c, input logic [LANES-1:0] e);
      @(posedge clk);
      frame_sym_in <= s;
      code_invalid_in <= c;
      disparity_err_in <= e;
      @(posedge clk);
      frame_sym_in <= '0;
      code_invalid_in <= '0;
      disparity_err_in <= '0;
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1;
      wait_up;
      ahb(0, OFS_STATUS, 0);
      chk(rd, 32'h0041_000f);
      ahb(0, 32'h10, 0);
      chk(rd, 0);
      ahb(1, OFS_CTRL, 32'h2);
      ahb(0, OFS_CTRL, 0);
      chk(rd, 32'h2);
      chk(transceiver_pdown, 1);
      ahb(1, OFS_CTRL, 0);
      @(posedge clk);
      power_down_in <= 1;
      @(posedge clk);
      power_down_in <= 0;
      for (int i = 0; i < 8; i++) begin
         pulse(ftab[i][4:1], '0, '0);
         chk(frame_fault, ftab[i][0]);
      end
      pulse('0, 4'h1, '0);
      chk({symbol_fault, fatal_fault}, 2'b10);
      repeat (40) @(posedge clk);
      pulse('0, '0, 4'h8);
      chk({symbol_fault, fatal_fault}, 2'b10);
      repeat (40) @(posedge clk);
      repeat (4) pulse('0, 4'h2, '0);
      chk(fatal_fault, 1);
      wait_up;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         hw_err_in <= hw_err_t'(3'b001 << i);
         @(posedge clk);
         hw_err_in <= '0;
         @(negedge clk);
         chk({fatal_fault, channel_up}, 2'b10);
         wait_up;
      end
      ahb(0, OFS_COUNTS, 0);
      chk(rd, 32'h0404_0006);
      @(posedge clk);
      core_reset_in <= 1;
      @(posedge clk);
      core_reset_in <= 0;
      @(negedge clk);
      chk(channel_up, 0);
      wait_up;
      ahb(1, OFS_CTRL, 32'h1);
      @(posedge clk);
      @(negedge clk);
      chk(channel_up, 0);
      wait_up;
      ahb(1, OFS_CTRL, 32'h4);
      @(posedge clk);
      partner_restart_in <= 1;
      @(posedge clk);
      partner_restart_in <= 0;
      @(negedge clk);
      chk({channel_up, lane_restart}, 2'b01);
      wait_up;
      chk(rx_deliver_en, 0);
      transceiver_reset_raw <= 1;
      repeat (12) @(posedge init_clk);
      chk(transceiver_reset, 1);
      transceiver_reset_raw <= 0;
      repeat (12) @(posedge init_clk);
      chk(transceiver_reset, 0);
      wrap_up;
   end
endmodule
